// [hw/int_arith_pkg.sv]
// Purpose: Shared encodings, patterns and clock counts of the add/sub decoder
// Assumes: Opcode and mod-reg-r/m bytes arrive already aligned by the queue
// Notes: Clock counts do not depend on the processor operating mode
package int_arith_pkg;

	typedef enum logic [2:0] {
		op_none = 3'h0,
		op_add = 3'h1,
		op_add_carry = 3'h2,
		op_subtract = 3'h3,
		op_subtract_borrow = 3'h4,
		op_increment = 3'h5,
		op_decrement = 3'h6
	} op_type;

	typedef enum logic [2:0] {
		form_none = 3'h0,
		form_reg_reg = 3'h1,
		form_reg_to_mem = 3'h2,
		form_mem_to_reg = 3'h3,
		form_imm_rm = 3'h4,
		form_imm_acc = 3'h5,
		form_unary_rm = 3'h6,
		form_short_reg = 3'h7
	} form_type;

	typedef enum logic [1:0] {
		width_byte = 2'h0,
		width_word = 2'h1,
		width_dword = 2'h2
	} width_type;

	// Opcode bits [7:2] of the two-operand mod-reg-r/m forms
	localparam logic [5:0] ADD_RM_BASE = 6'h00;
	localparam logic [5:0] ADC_RM_BASE = 6'h04;
	localparam logic [5:0] BORROW_RM_BASE = 6'h06;
	localparam logic [5:0] SUB_RM_BASE = 6'h0a;
	localparam logic [5:0] IMM_GROUP = 6'h20;
	// Opcode bits [7:1] of the accumulator short forms and unary group
	localparam logic [6:0] ADD_ACC_OPC = 7'h02;
	localparam logic [6:0] ADC_ACC_OPC = 7'h0a;
	localparam logic [6:0] BORROW_ACC_OPC = 7'h0e;
	localparam logic [6:0] SUB_ACC_OPC = 7'h16;
	localparam logic [6:0] INCDEC_GROUP = 7'h7f;
	// Opcode bits [7:3] of the one-byte increment
	localparam logic [4:0] INC_SHORT_OPC = 5'h08;

	// Reg field extensions
	localparam logic [2:0] EXT_ADD = 3'h0;
	localparam logic [2:0] EXT_ADC = 3'h2;
	localparam logic [2:0] EXT_BORROW = 3'h3;
	localparam logic [2:0] EXT_SUB = 3'h5;
	localparam logic [2:0] EXT_INC = 3'h0;
	localparam logic [2:0] EXT_DECREMENT = 3'h1;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [2:0] ACC_REG = 3'h0;

	// Execution clock counts
	localparam logic [3:0] CLK_REG = 4'h2;
	localparam logic [3:0] CLK_REG_TO_MEM = 4'h7;
	localparam logic [3:0] CLK_MEM_TO_REG = 4'h6;
	localparam logic [3:0] CLK_IMM_MEM = 4'h7;
	localparam logic [3:0] CLK_UNARY_MEM = 4'h6;
	localparam logic [3:0] CLK_ACC = 4'h2;

endpackage : int_arith_pkg

// [hw/immediate_extender.sv]
// Purpose: Widens the raw immediate to the operand width
// Assumes: Raw immediate is little-endian, low byte in bits 7:0
// Notes: Purely combinational; the decoder registers the result
`timescale 1ns/10ps
module immediate_extender (
	input wire logic [31:0] imm_raw_i,
	input wire logic byte_imm_i,
	input wire logic sign_extend_i,
	input wire int_arith_pkg::width_type width_i,
	output logic [31:0] imm_o
);
	import int_arith_pkg::*;

	logic [31:0] ext;

	always_comb begin
		ext = imm_raw_i;
		if (byte_imm_i) begin
			if (sign_extend_i) begin
				ext = {{24{imm_raw_i[7]}}, imm_raw_i[7:0]};
			end else begin
				ext = {24'h000000, imm_raw_i[7:0]};
			end
		end
		// Upper bits cleared so the datapath never sees stale bytes
		unique case (width_i)
			width_byte: imm_o = {24'h000000, ext[7:0]};
			width_word: imm_o = {16'h0000, ext[15:0]};
			default: imm_o = ext;
		endcase
	end

endmodule : immediate_extender

// [hw/integer_add_sub_decoder.sv]
// Purpose: Decodes add, add-carry, subtract, borrow, increment, decrement
// Assumes: opcode, modrm and immediate are valid together with instr_valid_i
// Notes: One cycle of latency; fields hold until the next valid instruction
// Behaviour
// - 100000sw with reg 000 is immediate add; 2 clocks register, 7 memory.
// - 0000010w is immediate add to accumulator, 2 clocks.
// - Add-carry 000100dw reg-reg 2, reg to memory 7, memory to reg 6.
// - 100000sw with reg 010 is immediate add-carry; 2 or 7 clocks.
// - 0001010w is immediate add-carry to accumulator, 2 clocks.
// - Increment via 1111111w reg 000 in 2/6, or 01000rrr in 2.
// - Subtract 001010dw register 2, register from memory 7, memory 6.
// - 100000sw with reg 101 is immediate subtract; 2 or 7 clocks.
// - 0010110w is immediate subtract from accumulator, 2 clocks.
// - Borrow-subtract 000110dw register 2, to memory 7, to register 6.
// - 100000sw with reg 011 is immediate borrow-subtract; 2 or 7 clocks.
// - 0001110w is immediate borrow-subtract from accumulator, 2 clocks.
// - 1111111w with reg 001 is decrement; 2 clocks register, 6 memory.
`timescale 1ns/10ps
module integer_add_sub_decoder
	import int_arith_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic instr_valid_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] modrm_i,
	input wire logic [31:0] imm_i,
	input wire logic opsize32_i,
	output logic decoded_valid_o,
	output logic unsupported_o,
	output int_arith_pkg::op_type op_o,
	output int_arith_pkg::form_type form_o,
	output int_arith_pkg::width_type width_o,
	output logic mem_operand_o,
	output logic reg_is_dest_o,
	output logic [2:0] reg_sel_o,
	output logic [2:0] rm_sel_o,
	output logic has_imm_o,
	output logic [31:0] imm_o,
	output logic [3:0] clock_count_o
);
	import int_arith_pkg::*;

	op_type rm_op, imm_op, acc_op;
	op_type op_d, op_q;
	form_type form_d, form_q;
	width_type width_d, width_q;
	logic hit_d, is_mem, full_w, byte_imm_d, sext_d, has_imm_d;
	logic reg_dest_d, mem_d;
	logic [2:0] reg_sel_d, rm_sel_d;
	logic [3:0] clk_d, clk_q;
	logic [31:0] imm_ext;
	logic valid_q, unsup_q, mem_q, reg_dest_q, has_imm_q;
	logic [2:0] reg_sel_q, rm_sel_q;
	logic [31:0] imm_q;

	always_comb begin
		case (opcode_i[7:2])
			ADD_RM_BASE: rm_op = op_add;
			ADC_RM_BASE: rm_op = op_add_carry;
			SUB_RM_BASE: rm_op = op_subtract;
			BORROW_RM_BASE: rm_op = op_subtract_borrow;
			default: rm_op = op_none;
		endcase
		case (modrm_i[5:3])
			EXT_ADD: imm_op = op_add;
			EXT_ADC: imm_op = op_add_carry;
			EXT_SUB: imm_op = op_subtract;
			EXT_BORROW: imm_op = op_subtract_borrow;
			default: imm_op = op_none;
		endcase
		case (opcode_i[7:1])
			ADD_ACC_OPC: acc_op = op_add;
			ADC_ACC_OPC: acc_op = op_add_carry;
			SUB_ACC_OPC: acc_op = op_subtract;
			BORROW_ACC_OPC: acc_op = op_subtract_borrow;
			default: acc_op = op_none;
		endcase
	end

	always_comb begin
		is_mem = modrm_i[7:6] != MOD_REG;
		hit_d = 1'b0;
		op_d = op_none;
		form_d = form_none;
		full_w = opcode_i[0];
		byte_imm_d = 1'b0;
		sext_d = 1'b0;
		has_imm_d = 1'b0;
		reg_dest_d = 1'b0;
		mem_d = 1'b0;
		reg_sel_d = modrm_i[5:3];
		rm_sel_d = modrm_i[2:0];
		clk_d = 4'h0;
		if (rm_op != op_none) begin
			hit_d = 1'b1;
			op_d = rm_op;
			mem_d = is_mem;
			reg_dest_d = opcode_i[1];
			if (!is_mem) begin
				form_d = form_reg_reg;
				clk_d = CLK_REG;
			end else if (opcode_i[1]) begin
				form_d = form_mem_to_reg;
				clk_d = CLK_MEM_TO_REG;
			end else begin
				form_d = form_reg_to_mem;
				clk_d = CLK_REG_TO_MEM;
			end
		end else if (opcode_i[7:2] == IMM_GROUP && imm_op != op_none) begin
			hit_d = 1'b1;
			op_d = imm_op;
			form_d = form_imm_rm;
			mem_d = is_mem;
			has_imm_d = 1'b1;
			// Byte immediate unless full width with no sign extension
			byte_imm_d = opcode_i[1] | ~opcode_i[0];
			sext_d = opcode_i[1];
			clk_d = is_mem ? CLK_IMM_MEM : CLK_REG;
		end else if (acc_op != op_none) begin
			hit_d = 1'b1;
			op_d = acc_op;
			form_d = form_imm_acc;
			has_imm_d = 1'b1;
			byte_imm_d = ~opcode_i[0];
			reg_dest_d = 1'b1;
			reg_sel_d = ACC_REG;
			clk_d = CLK_ACC;
		end else if (opcode_i[7:1] == INCDEC_GROUP &&
			(modrm_i[5:3] == EXT_INC || modrm_i[5:3] == EXT_DECREMENT)) begin
			hit_d = 1'b1;
			op_d = (modrm_i[5:3] == EXT_INC) ? op_increment : op_decrement;
			form_d = form_unary_rm;
			mem_d = is_mem;
			clk_d = is_mem ? CLK_UNARY_MEM : CLK_REG;
		end else if (opcode_i[7:3] == INC_SHORT_OPC) begin
			// One-byte form has no width bit; always full size
			hit_d = 1'b1;
			op_d = op_increment;
			form_d = form_short_reg;
			full_w = 1'b1;
			reg_dest_d = 1'b1;
			reg_sel_d = opcode_i[2:0];
			clk_d = CLK_REG;
		end
		if (!full_w) begin
			width_d = width_byte;
		end else begin
			width_d = opsize32_i ? width_dword : width_word;
		end
	end

	immediate_extender u_imm (
		.imm_raw_i(imm_i),
		.byte_imm_i(byte_imm_d),
		.sign_extend_i(sext_d),
		.width_i(width_d),
		.imm_o(imm_ext)
	);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			valid_q <= 1'b0;
			unsup_q <= 1'b0;
		end else begin
			valid_q <= instr_valid_i & hit_d;
			unsup_q <= instr_valid_i & ~hit_d;
		end
	end

	// Fields hold between instructions so the datapath may sample late
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			op_q <= op_none;
			form_q <= form_none;
			width_q <= width_byte;
			mem_q <= 1'b0;
			reg_dest_q <= 1'b0;
			reg_sel_q <= 3'h0;
			rm_sel_q <= 3'h0;
			has_imm_q <= 1'b0;
			imm_q <= 32'h00000000;
			clk_q <= 4'h0;
		end else if (instr_valid_i) begin
			op_q <= op_d;
			form_q <= form_d;
			width_q <= width_d;
			mem_q <= mem_d;
			reg_dest_q <= reg_dest_d;
			reg_sel_q <= reg_sel_d;
			rm_sel_q <= rm_sel_d;
			has_imm_q <= has_imm_d;
			imm_q <= has_imm_d ? imm_ext : 32'h00000000;
			clk_q <= clk_d;
		end
	end

	assign decoded_valid_o = valid_q;
	assign unsupported_o = unsup_q;
	assign op_o = op_q;
	assign form_o = form_q;
	assign width_o = width_q;
	assign mem_operand_o = mem_q;
	assign reg_is_dest_o = reg_dest_q;
	assign reg_sel_o = reg_sel_q;
	assign rm_sel_o = rm_sel_q;
	assign has_imm_o = has_imm_q;
	assign imm_o = imm_q;
	assign clock_count_o = clk_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	sequence seq_imm_group(logic [2:0] ext);
		instr_valid_i && opcode_i[7:2] == IMM_GROUP && modrm_i[5:3] == ext;
	endsequence

	sequence seq_imm_rm_out(op_type op);
		decoded_valid_o && op_o == op && form_o == form_imm_rm && has_imm_o &&
		clock_count_o == (mem_operand_o ? CLK_IMM_MEM : CLK_REG) &&
		mem_operand_o == ($past(modrm_i[7:6]) != MOD_REG);
	endsequence

	sequence seq_rm_out(op_type op);
		decoded_valid_o && op_o == op && reg_is_dest_o == $past(opcode_i[1]) &&
		mem_operand_o == ($past(modrm_i[7:6]) != MOD_REG) &&
		clock_count_o == (!mem_operand_o ? CLK_REG :
		($past(opcode_i[1]) ? CLK_MEM_TO_REG : CLK_REG_TO_MEM));
	endsequence

	sequence seq_acc_out(op_type op);
		decoded_valid_o && op_o == op && form_o == form_imm_acc &&
		reg_sel_o == ACC_REG && clock_count_o == CLK_ACC;
	endsequence

	AST_IMM_ADD: assert property (seq_imm_group(EXT_ADD) |=>
		seq_imm_rm_out(op_add))
		else $error("immediate add misdecoded");
	AST_ACC_ADD: assert property (instr_valid_i &&
		opcode_i[7:1] == ADD_ACC_OPC |=> seq_acc_out(op_add))
		else $error("accumulator add misdecoded");
	AST_RM_ADC: assert property (instr_valid_i &&
		opcode_i[7:2] == ADC_RM_BASE |=> seq_rm_out(op_add_carry))
		else $error("add-carry form misdecoded");
	AST_IMM_ADC: assert property (seq_imm_group(EXT_ADC) |=>
		seq_imm_rm_out(op_add_carry))
		else $error("immediate add-carry misdecoded");
	AST_ACC_ADC: assert property (instr_valid_i &&
		opcode_i[7:1] == ADC_ACC_OPC |=> seq_acc_out(op_add_carry))
		else $error("accumulator add-carry misdecoded");
	AST_INC: assert property (instr_valid_i &&
		(opcode_i[7:3] == INC_SHORT_OPC || opcode_i[7:1] == INCDEC_GROUP &&
		modrm_i[5:3] == EXT_INC) |=> decoded_valid_o &&
		op_o == op_increment &&
		clock_count_o == (mem_operand_o ? CLK_UNARY_MEM : CLK_REG))
		else $error("increment misdecoded");
	AST_RM_SUB: assert property (instr_valid_i &&
		opcode_i[7:2] == SUB_RM_BASE |=> seq_rm_out(op_subtract))
		else $error("subtract form misdecoded");
	AST_IMM_SUB: assert property (seq_imm_group(EXT_SUB) |=>
		seq_imm_rm_out(op_subtract))
		else $error("immediate subtract misdecoded");
	AST_ACC_SUB: assert property (instr_valid_i &&
		opcode_i[7:1] == SUB_ACC_OPC |=> seq_acc_out(op_subtract))
		else $error("accumulator subtract misdecoded");
	AST_RM_BORROW: assert property (instr_valid_i &&
		opcode_i[7:2] == BORROW_RM_BASE |=> seq_rm_out(op_subtract_borrow))
		else $error("borrow form misdecoded");
	AST_IMM_BORROW: assert property (seq_imm_group(EXT_BORROW) |=>
		seq_imm_rm_out(op_subtract_borrow))
		else $error("immediate borrow misdecoded");
	AST_ACC_BORROW: assert property (instr_valid_i &&
		opcode_i[7:1] == BORROW_ACC_OPC |=> seq_acc_out(op_subtract_borrow))
		else $error("accumulator borrow misdecoded");
	AST_DECREMENT: assert property (instr_valid_i &&
		opcode_i[7:1] == INCDEC_GROUP && modrm_i[5:3] == EXT_DECREMENT |=>
		decoded_valid_o && op_o == op_decrement && form_o == form_unary_rm &&
		clock_count_o ==
		($past(modrm_i[7:6]) == MOD_REG ? CLK_REG : CLK_UNARY_MEM))
		else $error("decrement misdecoded");
	AST_WIDTH: assert property (instr_valid_i && hit_d &&
		opcode_i[7:3] != INC_SHORT_OPC |=>
		(width_o == width_byte) == !$past(opcode_i[0]) &&
		(width_o == width_dword) ==
		($past(opcode_i[0]) && $past(opsize32_i)))
		else $error("operand width wrong");
	AST_SEXT: assert property (instr_valid_i &&
		opcode_i[7:2] == IMM_GROUP && modrm_i[5:3] == EXT_ADD &&
		opcode_i[1:0] == 2'h3 && imm_i[7] |=> imm_o[15:8] == 8'hff)
		else $error("byte immediate not sign-extended");

endmodule : integer_add_sub_decoder

// [verification/fetch_queue_model.sv]
// Purpose: Fetch queue stand-in that hands aligned bytes to the decoder
// Assumes: Bench raises req_i for every cycle that carries an instruction
// Notes: Idle bytes show the inverse of the last ones, never a stale copy
`timescale 1ns/10ps
module fetch_queue_model (
	input wire logic clock_i,
	input wire logic req_i,
	input wire logic [47:0] bytes_i,
	output logic valid_o,
	output logic [7:0] opcode_o,
	output logic [7:0] modrm_o,
	output logic [31:0] imm_o
);
	logic [47:0] last_q;

	initial last_q = 48'h0;
	always @(posedge clock_i) begin
		if (req_i) begin
			last_q <= bytes_i;
		end
	end
	// Decoder must not lean on bytes that the queue no longer qualifies
	assign valid_o = req_i;
	assign {opcode_o, modrm_o, imm_o} = req_i ? bytes_i : ~last_q;
endmodule : fetch_queue_model

// [verification/test_integer_add_sub_decoder.sv]
// Purpose: Self-checking bench for the add/sub decoder
// Assumes: Instructions reach the decoder through the fetch queue model
// Notes: Expected fields are worked out per opcode, never read back
`timescale 1ns/10ps
module test_integer_add_sub_decoder;
	import int_arith_pkg::*;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic req = 1'b0;
	logic opsize32_i = 1'b0;
	logic [47:0] bytes = 48'h0;
	logic instr_valid_i;
	logic [7:0] opcode_i;
	logic [7:0] modrm_i;
	logic [31:0] imm_i;
	logic decoded_valid_o;
	logic unsupported_o;
	op_type op_o;
	form_type form_o;
	width_type width_o;
	logic mem_operand_o;
	logic reg_is_dest_o;
	logic [2:0] reg_sel_o;
	logic [2:0] rm_sel_o;
	logic has_imm_o;
	logic [31:0] imm_o;
	logic [3:0] clock_count_o;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	wire [31:0] fld = {19'h0, op_o, form_o, width_o, mem_operand_o,
		clock_count_o};

	always #2 clock_i = ~clock_i;

	fetch_queue_model fetch_queue_model_inst (.clock_i, .req_i(req),
		.bytes_i(bytes), .valid_o(instr_valid_i), .opcode_o(opcode_i),
		.modrm_o(modrm_i), .imm_o(imm_i));
	integer_add_sub_decoder integer_add_sub_decoder_inst (.clock_i,
		.sys_rst_i, .instr_valid_i, .opcode_i, .modrm_i, .imm_i,
		.opsize32_i, .decoded_valid_o, .unsupported_o, .op_o, .form_o,
		.width_o, .mem_operand_o, .reg_is_dest_o, .reg_sel_o, .rm_sel_o,
		.has_imm_o, .imm_o, .clock_count_o);

	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	task automatic cmp(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : cmp

	// One instruction, then a look at the answer one edge later
	task automatic send(logic [47:0] b, logic sz, logic ok);
		@(posedge clock_i);
		req <= 1'b1;
		bytes <= b;
		opsize32_i <= sz;
		@(posedge clock_i);
		req <= 1'b0;
		#1;
		cmp("valid", {31'h0, decoded_valid_o}, {31'h0, ok});
		cmp("unsupported", {31'h0, unsupported_o}, {31'h0, !ok});
	endtask : send

	task automatic test_imm_group;
		logic [2:0] ext [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
		op_type ops [4] = '{op_add, op_add_carry, op_subtract_borrow,
			op_subtract};
		for (int i = 0; i < 4; i++) begin
			for (int m = 0; m < 2; m++) begin
				send({8'h83, m ? 2'h0 : 2'h3, ext[i], 3'h5, 32'h80}, 1'b1,
					1'b1);
				cmp("imm fld", fld, {19'h0, ops[i], form_imm_rm, width_dword,
					m[0], m ? 4'h7 : 4'h2});
				cmp("imm sext", imm_o, 32'hffffff80);
			end
		end
		send({8'h81, 8'hc1, 32'h12345678}, 1'b0, 1'b1);
		cmp("word fld", fld, {19'h0, op_add, form_imm_rm, width_word,
			1'b0, 4'h2});
		cmp("word imm", imm_o, 32'h5678);
		send({8'h80, 8'h28, 32'h12345678}, 1'b1, 1'b1);
		cmp("byte fld", fld, {19'h0, op_subtract, form_imm_rm, width_byte,
			1'b1, 4'h7});
		cmp("byte imm", imm_o, 32'h78);
		send({8'h82, 8'hcc, 32'h0}, 1'b1, 1'b0);
		cmp("bad ext", {29'h0, op_o}, {29'h0, op_none});
		$display("test_imm_group done");
	endtask : test_imm_group

	task automatic test_rm_forms;
		logic [5:0] base [3] = '{6'h04, 6'h0a, 6'h06};
		op_type ops [3] = '{op_add_carry, op_subtract, op_subtract_borrow};
		for (int i = 0; i < 3; i++) begin
			for (int k = 0; k < 4; k++) begin
				send({base[i], k[1], 1'b0, k[0] ? 2'h1 : 2'h3, 6'h33, 32'h0},
					1'b1, 1'b1);
				cmp("rm fld", fld, {19'h0, ops[i], k[0] ? (k[1] ?
					form_mem_to_reg : form_reg_to_mem) : form_reg_reg, width_byte,
					k[0], k[0] ? (k[1] ? 4'h6 : 4'h7) : 4'h2});
				cmp("rm regs", {24'h0, reg_is_dest_o, reg_sel_o, rm_sel_o,
					has_imm_o}, {24'h0, k[1], 6'h33, 1'b0});
			end
		end
		$display("test_rm_forms done");
	endtask : test_rm_forms

	task automatic test_acc;
		logic [6:0] opc [4] = '{7'h02, 7'h0a, 7'h16, 7'h0e};
		op_type ops [4] = '{op_add, op_add_carry, op_subtract,
			op_subtract_borrow};
		for (int i = 0; i < 4; i++) begin
			for (int w = 0; w < 2; w++) begin
				send({opc[i], w[0], 8'hc9, 32'h12345678}, 1'b0, 1'b1);
				cmp("acc fld", fld, {19'h0, ops[i], form_imm_acc, w ? width_word
					: width_byte, 1'b0, 4'h2});
				cmp("acc imm", imm_o, w ? 32'h5678 : 32'h78);
				cmp("acc regs", {27'h0, reg_is_dest_o, reg_sel_o, has_imm_o},
					32'h11);
			end
		end
		$display("test_acc done");
	endtask : test_acc

	task automatic test_incdec;
		for (int k = 0; k < 8; k++) begin
			send({7'h7f, k[2], k[0] ? 2'h2 : 2'h3, 2'h0, k[1], 3'h7, 32'h0},
				1'b1, 1'b1);
			cmp("unary fld", fld, {19'h0, k[1] ? op_decrement : op_increment,
				form_unary_rm, k[2] ? width_dword : width_byte, k[0],
				k[0] ? 4'h6 : 4'h2});
		end
		send({8'h45, 40'h0}, 1'b0, 1'b1);
		cmp("short fld", fld, {19'h0, op_increment, form_short_reg,
			width_word, 1'b0, 4'h2});
		cmp("short reg", {29'h0, reg_sel_o}, 32'h5);
		send({8'h4d, 40'h0}, 1'b0, 1'b0);
		$display("test_incdec done");
	endtask : test_incdec

	// Back-to-back instructions; a mid-run reset swallows the third one
	task automatic test_burst_reset;
		@(posedge clock_i);
		req <= 1'b1;
		bytes <= {8'h40, 40'h0};
		@(posedge clock_i);
		bytes <= {8'hfe, 8'hc9, 32'h0};
		#1;
		cmp("burst 1", {28'h0, decoded_valid_o, op_o},
			{28'h0, 1'b1, op_increment});
		@(posedge clock_i);
		bytes <= {8'h05, 8'h00, 32'h00001234};
		sys_rst_i <= 1'b1;
		#1;
		cmp("burst 2", {28'h0, decoded_valid_o, op_o},
			{28'h0, 1'b1, op_decrement});
		@(posedge clock_i);
		req <= 1'b0;
		sys_rst_i <= 1'b0;
		#1;
		cmp("pulse end", {31'h0, decoded_valid_o}, 32'h0);
		cmp("reset fld", fld, 32'h0);
		// First request straight after the mid-run reset
		send({8'h05, 8'h00, 32'h00001234}, 1'b0, 1'b1);
		cmp("after reset", fld, {19'h0, op_add, form_imm_acc, width_word,
			1'b0, 4'h2});
		cmp("after imm", imm_o, 32'h00001234);
		$display("test_burst_reset done");
	endtask : test_burst_reset

	initial begin
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		cmp("init fld", fld, 32'h0);
		test_imm_group();
		test_rm_forms();
		test_acc();
		test_incdec();
		test_burst_reset();
		wrap_up();
	end

	// Whole run needs about a hundred cycles; the ceiling leaves ample slack
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 1000) begin
			fails++;
			wrap_up();
		end
	end
endmodule : test_integer_add_sub_decoder
